// [logic/sesum_pkg.sv]
// constants for the status event summary block
// assumes a command decoder that turns common commands into strobes
// Contract
// - execution error sets event bit 4
// - device dependent error sets event bit 3
// - read of empty output queue sets bit 2
// - lost response data also sets bit 2
// - request control sets event bit 1
// - event register cleared by query or clear
// - event read, mask read, mask write honoured
// - keep 8-bit status byte of summaries
// - keep 8-bit service request enable mask
// - summary true when any enabled event true
// - bit 7 summarises operation, cdma, measuring
// - bit 6 is rqs or mss, unmaskable
// - bit 5 summarises masked standard events
// - bit 4 carries message available
// - bit 3 summarises questionable and calibration
// - status byte bit 2 unused
// - bit 1 carries hardware two summary
// - bit 0 summarises hw1, comm, serial ports
// - mss is or of masked byte, no bit 6
// - serial poll clears rqs only
// - bit 6 of written mask ignored
// - power cycle sets event bit 7
package sesum_pkg;
  localparam int EV_OPC = 0;
  localparam int EV_RQC = 1;
  localparam int EV_QRY = 2;
  localparam int EV_DDE = 3;
  localparam int EV_EXE = 4;
  localparam int EV_CMD = 5;
  localparam int EV_PON = 7;
  localparam int SB_DEV = 0;
  localparam int SB_HW2 = 1;
  localparam int SB_UNUSED = 2;
  localparam int SB_QUES = 3;
  localparam int SB_MAV = 4;
  localparam int SB_ESB = 5;
  localparam int SB_RQS = 6;
  localparam int SB_OPER = 7;
  localparam logic [15:0] EVENT_RESET = 16'h0080;
  localparam logic [15:0] EVENT_USED = 16'h00BF;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [7:0] SRE_RESET = 8'h00;
  localparam logic [7:0] SRE_WRITABLE = 8'hBF;
endpackage

// [logic/sesum_status.sv]
// standard event register, status byte and service request logic
// assumes one-cycle command strobes from a parser on the same clock
`timescale 1ns/100ps
module sesum_status import sesum_pkg::*; (
  input wire logic clock,
  input wire logic reset,
  input wire logic evExecError,
  input wire logic evDeviceError,
  input wire logic evQueryEmpty,
  input wire logic evQueryLost,
  input wire logic evReqControl,
  input wire logic evCommandError,
  input wire logic opcCommand,
  input wire logic opsPending,
  input wire logic esrQuery,
  input wire logic clsCommand,
  input wire logic eseWrite,
  input wire logic [15:0] eseData,
  input wire logic sreWrite,
  input wire logic [7:0] sreData,
  input wire logic serialPoll,
  input wire logic sumOperation,
  input wire logic sumCdma,
  input wire logic sumMeasuring,
  input wire logic msgAvailable,
  input wire logic sumQuestionable,
  input wire logic sumCalibration,
  input wire logic sumHardware2,
  input wire logic sumHardware1,
  input wire logic sumCommunicate,
  input wire logic sumSerial1,
  input wire logic sumSerial2,
  output logic [15:0] eventRead,
  output logic [15:0] enableRead,
  output logic [7:0] stbRead,
  output logic [7:0] spollRead,
  output logic [7:0] sreRead,
  output logic srqOut
);
  logic [15:0] event_q, event_d, enable_q;
  logic [7:0] sre_q, stb_q, spoll_q;
  logic opcArmed_q, rqs_q, mss_q, srq_q;
  logic [15:0] eventSet;
  logic [7:0] summary;
  logic mss, opcDone, clrEvent;

  // device power-up counts as the power cycle, so reset presets bit 7
  assign opcDone = opcArmed_q && !opsPending;
  assign clrEvent = esrQuery || clsCommand;
  always_comb begin
    eventSet = 16'h0000;
    eventSet[EV_EXE] = evExecError;
    eventSet[EV_DDE] = evDeviceError;
    eventSet[EV_QRY] = evQueryEmpty || evQueryLost;
    eventSet[EV_RQC] = evReqControl;
    eventSet[EV_OPC] = opcDone;
    eventSet[EV_CMD] = evCommandError;
  end
  // set wins over clear so an event in the read cycle survives
  assign event_d = ((clrEvent ? 16'h0000 : event_q) | eventSet) & EVENT_USED;

  assign summary[SB_OPER] = sumOperation || sumCdma || sumMeasuring;
  assign summary[SB_RQS] = 1'b0;
  assign summary[SB_ESB] = |(event_q & enable_q);
  assign summary[SB_MAV] = msgAvailable;
  assign summary[SB_QUES] = sumQuestionable || sumCalibration;
  assign summary[SB_UNUSED] = 1'b0;
  assign summary[SB_HW2] = sumHardware2;
  assign summary[SB_DEV] = sumHardware1 || sumCommunicate || sumSerial1 || sumSerial2;
  assign mss = |(summary & sre_q & SRE_WRITABLE);

  always_ff @(posedge clock) begin
    if (reset) begin
      event_q <= EVENT_RESET;
      opcArmed_q <= 1'b0;
    end else begin
      event_q <= event_d;
      opcArmed_q <= (opcArmed_q && !opcDone && !clsCommand) || opcCommand;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      enable_q <= ENABLE_RESET;
      sre_q <= SRE_RESET;
    end else begin
      if (eseWrite) enable_q <= eseData & EVENT_USED;
      if (sreWrite) sre_q <= sreData & SRE_WRITABLE;
    end
  end

  // rqs rises on a new reason for service; a poll drops it, new rise wins
  always_ff @(posedge clock) begin
    if (reset) begin
      rqs_q <= 1'b0;
      mss_q <= 1'b0;
    end else begin
      mss_q <= mss;
      rqs_q <= (mss && !mss_q) || (rqs_q && !serialPoll && mss);
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      stb_q <= 8'h00;
      spoll_q <= 8'h00;
      srq_q <= 1'b0;
    end else begin
      stb_q <= {summary[7], mss, summary[5:0]};
      spoll_q <= {summary[7], rqs_q && !serialPoll, summary[5:0]};
      srq_q <= rqs_q && !serialPoll;
    end
  end

  assign eventRead = event_q;
  assign enableRead = enable_q;
  assign stbRead = stb_q;
  assign spollRead = spoll_q;
  assign sreRead = sre_q;
  assign srqOut = srq_q;

  property p_esr_clear;
    @(posedge clock) disable iff (reset)
    (esrQuery && !(|eventSet)) |=> (event_q == 16'h0000);
  endproperty
  a_esr_clear: assert property (p_esr_clear) else $error("event not cleared");

  property p_exec_latch;
    @(posedge clock) disable iff (reset)
    evExecError |=> event_q[EV_EXE] ##1 (event_q[EV_EXE] || $past(clrEvent));
  endproperty
  a_exec_latch: assert property (p_exec_latch) else $error("exec bit lost");

  property p_query_err;
    @(posedge clock) disable iff (reset)
    (evQueryEmpty || evQueryLost) |=> event_q[EV_QRY];
  endproperty
  a_query_err: assert property (p_query_err) else $error("query bit not set");

  property p_opc_only;
    @(posedge clock) disable iff (reset)
    $rose(event_q[EV_OPC]) |-> $past(opcArmed_q);
  endproperty
  a_opc_only: assert property (p_opc_only) else $error("opc without command");

  property p_sre_bit6;
    @(posedge clock) disable iff (reset)
    sreWrite |=> !sre_q[SB_RQS] && sre_q[7] == $past(sreData[7]);
  endproperty
  a_sre_bit6: assert property (p_sre_bit6) else $error("sre bit 6 kept");

  property p_stb_mss;
    @(posedge clock) disable iff (reset)
    1'b1 |=> stb_q[SB_RQS] == $past(mss) && !stb_q[SB_UNUSED];
  endproperty
  a_stb_mss: assert property (p_stb_mss) else $error("mss wrong");

  property p_esb;
    @(posedge clock) disable iff (reset)
    (|(event_q & enable_q)) |=> stb_q[SB_ESB];
  endproperty
  a_esb: assert property (p_esb) else $error("esb summary missing");

  property p_poll_clear;
    @(posedge clock) disable iff (reset)
    serialPoll |=> !spoll_q[SB_RQS] && !srq_q;
  endproperty
  a_poll_clear: assert property (p_poll_clear) else $error("rqs not cleared");

  property p_dev_set;
    @(posedge clock) disable iff (reset)
    evDeviceError |=> event_q[EV_DDE];
  endproperty
  a_dev_set: assert property (p_dev_set) else $error("device error bit not set");

  property p_query_lost;
    @(posedge clock) disable iff (reset)
    evQueryLost |=> event_q[EV_QRY];
  endproperty
  a_query_lost: assert property (p_query_lost) else $error("lost data bit not set");

  property p_req_control;
    @(posedge clock) disable iff (reset)
    evReqControl |=> event_q[EV_RQC];
  endproperty
  a_req_control: assert property (p_req_control) else $error("control bit not set");

  property p_cmd_set;
    @(posedge clock) disable iff (reset)
    evCommandError |=> event_q[EV_CMD];
  endproperty
  a_cmd_set: assert property (p_cmd_set) else $error("command bit not set");

  property p_event_hold;
    @(posedge clock) disable iff (reset)
    !clrEvent |=> ((event_q & $past(event_q)) == $past(event_q));
  endproperty
  a_event_hold: assert property (p_event_hold) else $error("event bit dropped");

  property p_cls_clear;
    @(posedge clock) disable iff (reset)
    (clsCommand && !(|eventSet)) |=> (event_q == 16'h0000);
  endproperty
  a_cls_clear: assert property (p_cls_clear) else $error("clear left events");

  property p_power_read;
    @(posedge clock) disable iff (reset)
    esrQuery |=> !event_q[EV_PON];
  endproperty
  a_power_read: assert property (p_power_read) else $error("power bit kept");

  property p_ese_write;
    @(posedge clock) disable iff (reset)
    eseWrite |=> (enable_q == ($past(eseData) & EVENT_USED));
  endproperty
  a_ese_write: assert property (p_ese_write) else $error("event mask not written");

  property p_ese_hold;
    @(posedge clock) disable iff (reset)
    !eseWrite |=> $stable(enable_q);
  endproperty
  a_ese_hold: assert property (p_ese_hold) else $error("event mask changed");

  property p_sre_write;
    @(posedge clock) disable iff (reset)
    sreWrite |=> (sre_q == ($past(sreData) & SRE_WRITABLE));
  endproperty
  a_sre_write: assert property (p_sre_write) else $error("request mask not written");

  property p_sre_hold;
    @(posedge clock) disable iff (reset)
    !sreWrite |=> $stable(sre_q);
  endproperty
  a_sre_hold: assert property (p_sre_hold) else $error("request mask changed");

  property p_oper_sum;
    @(posedge clock) disable iff (reset)
    (sumOperation || sumCdma || sumMeasuring) |=> stb_q[SB_OPER];
  endproperty
  a_oper_sum: assert property (p_oper_sum) else $error("bit 7 summary missing");

  property p_mav;
    @(posedge clock) disable iff (reset)
    msgAvailable |=> stb_q[SB_MAV] && spoll_q[SB_MAV];
  endproperty
  a_mav: assert property (p_mav) else $error("message available missing");

  property p_ques_sum;
    @(posedge clock) disable iff (reset)
    (sumQuestionable || sumCalibration) |=> stb_q[SB_QUES];
  endproperty
  a_ques_sum: assert property (p_ques_sum) else $error("bit 3 summary missing");

  property p_hw2_sum;
    @(posedge clock) disable iff (reset)
    1'b1 |=> (stb_q[SB_HW2] == $past(sumHardware2));
  endproperty
  a_hw2_sum: assert property (p_hw2_sum) else $error("bit 1 summary wrong");

  property p_dev_sum;
    @(posedge clock) disable iff (reset)
    (sumHardware1 || sumCommunicate || sumSerial1 || sumSerial2) |=> stb_q[SB_DEV];
  endproperty
  a_dev_sum: assert property (p_dev_sum) else $error("bit 0 summary missing");

  property p_dev_quiet;
    @(posedge clock) disable iff (reset)
    (!sumHardware1 && !sumCommunicate && !sumSerial1 && !sumSerial2) |=> !stb_q[SB_DEV];
  endproperty
  a_dev_quiet: assert property (p_dev_quiet) else $error("bit 0 set without cause");

  property p_unused_poll;
    @(posedge clock) disable iff (reset)
    1'b1 |=> !spoll_q[SB_UNUSED];
  endproperty
  a_unused_poll: assert property (p_unused_poll) else $error("unused poll bit set");

  property p_esb_quiet;
    @(posedge clock) disable iff (reset)
    !(|(event_q & enable_q)) |=> !stb_q[SB_ESB];
  endproperty
  a_esb_quiet: assert property (p_esb_quiet) else $error("bit 5 set without cause");

  property p_poll_keeps;
    @(posedge clock) disable iff (reset)
    serialPoll |=> (spoll_q[7] == stb_q[7]) && (spoll_q[5:0] == stb_q[5:0]);
  endproperty
  a_poll_keeps: assert property (p_poll_keeps) else $error("poll changed summaries");

  property p_mss_mask;
    @(posedge clock) disable iff (reset)
    (sre_q == 8'h00) |=> !stb_q[SB_RQS];
  endproperty
  a_mss_mask: assert property (p_mss_mask) else $error("mss without enable");

  property p_rqs_rise;
    @(posedge clock) disable iff (reset)
    (mss && !mss_q) |=> rqs_q;
  endproperty
  a_rqs_rise: assert property (p_rqs_rise) else $error("rqs not raised");

  property p_srq_follows;
    @(posedge clock) disable iff (reset)
    1'b1 |=> (srq_q == ($past(rqs_q) && !$past(serialPoll)));
  endproperty
  a_srq_follows: assert property (p_srq_follows) else $error("srq level wrong");

  property p_poll_drop;
    @(posedge clock) disable iff (reset)
    (serialPoll && !(mss && !mss_q)) |=> !rqs_q;
  endproperty
  a_poll_drop: assert property (p_poll_drop) else $error("rqs kept after poll");

  property p_opc_arm;
    @(posedge clock) disable iff (reset)
    opcCommand ##1 !opsPending |=> event_q[EV_OPC];
  endproperty
  a_opc_arm: assert property (p_opc_arm) else $error("opc bit not set");
endmodule // sesum_status

// [test/sesum_host.sv]
// host model: turns command codes from the bench into one-cycle strobes
// assumes each code is held for exactly one clock
`timescale 1ns/100ps
module sesum_host (
  input wire logic [2:0] op,
  input wire logic [15:0] arg,
  output logic esrQuery,
  output logic clsCommand,
  output logic eseWrite,
  output logic [15:0] eseData,
  output logic sreWrite,
  output logic [7:0] sreData,
  output logic serialPoll
);
  assign esrQuery = op == 3'h1;
  assign clsCommand = op == 3'h2;
  assign eseWrite = op == 3'h3;
  assign sreWrite = op == 3'h4;
  assign serialPoll = op == 3'h5;
  // data lines carry the inverted argument when idle so stale values are never trusted
  assign eseData = eseWrite ? arg : ~arg;
  assign sreData = sreWrite ? arg[7:0] : ~arg[7:0];
endmodule // sesum_host

// [test/testbench.sv]
// random and corner-case bench for the status event summary block
// assumes the host model above and one 25 MHz clock
`timescale 1ns/100ps
module testbench import sesum_pkg::*; ;
  logic clock = 0, reset = 1, opc = 0, pend = 0, esrQ, cls, eseW, sreW, poll, srq;
  logic [5:0] ev = 0;
  logic [10:0] sum = 0;
  logic [2:0] op = 0;
  logic [15:0] arg = 0, ex, eseD, evR, enR, eseM = 0, sb;
  logic [16:0] lf = 17'h108C3;
  logic [7:0] sreD, stb, spl, sreR, sreM = 0;
  int errors = 0, compares = 0;
  always #20 clock = ~clock;
  sesum_host host_m (.op(op), .arg(arg), .esrQuery(esrQ), .clsCommand(cls), .eseWrite(eseW),
    .eseData(eseD), .sreWrite(sreW), .sreData(sreD), .serialPoll(poll));
  sesum_status dut (.clock(clock), .reset(reset), .evExecError(ev[0]), .evDeviceError(ev[1]),
    .evQueryEmpty(ev[2]), .evQueryLost(ev[3]), .evReqControl(ev[4]), .evCommandError(ev[5]),
    .opcCommand(opc), .opsPending(pend), .esrQuery(esrQ), .clsCommand(cls), .eseWrite(eseW),
    .eseData(eseD), .sreWrite(sreW), .sreData(sreD), .serialPoll(poll), .sumOperation(sum[0]),
    .sumCdma(sum[1]), .sumMeasuring(sum[2]), .msgAvailable(sum[3]), .sumQuestionable(sum[4]),
    .sumCalibration(sum[5]), .sumHardware2(sum[6]), .sumHardware1(sum[7]),
    .sumCommunicate(sum[8]), .sumSerial1(sum[9]), .sumSerial2(sum[10]), .eventRead(evR),
    .enableRead(enR), .stbRead(stb), .spollRead(spl), .sreRead(sreR), .srqOut(srq));
  function automatic logic [16:0] nx(logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  function automatic logic [15:0] evx(logic [5:0] e);
    return {10'h000, e[5], e[0], e[1], e[2] | e[3], e[4], 1'b0};
  endfunction
  // byte as latched from the summaries, the events before the pulse and both masks
  function automatic logic [15:0] sbx(logic [10:0] s, logic [15:0] ev, logic [15:0] ese,
    logic [7:0] sre);
    logic [7:0] b;
    b = {|s[2:0], 1'b0, |(ev & ese), s[3], s[4] | s[5], 1'b0, s[6], |s[10:7]};
    b[SB_RQS] = |(b & sre);
    return {8'h00, b};
  endfunction
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cmd(logic [2:0] o, logic [15:0] a);
    @(posedge clock);
    op <= o;
    arg <= a;
    @(posedge clock);
    op <= 3'h0;
  endtask
  task automatic pulse(logic [5:0] e, logic o);
    @(posedge clock);
    ev <= e;
    opc <= o;
    @(posedge clock);
    ev <= 6'h00;
    opc <= 1'b0;
  endtask
  task automatic test_done();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock) chk("power event", 16'h0080, evR);
    cmd(3'h1, 16'h0000);
    ex = 16'h0000;
    @(negedge clock) chk("query clear", ex, evR);
    for (int i = 0; i < 40; i++) begin
      lf = nx(lf);
      @(posedge clock) sum <= lf[16:6];
      sb = sbx(lf[16:6], ex, eseM, sreM);
      pulse(lf[5:0], 1'b0);
      ex |= evx(lf[5:0]);
      @(negedge clock) chk("event", ex, evR);
      chk("status byte", sb, {8'h00, stb});
      chk("unused bit", 16'h0000, {15'h0000, stb[SB_UNUSED]});
      if (lf[16]) begin
        cmd(lf[15] ? 3'h2 : 3'h1, 16'h0000);
        ex = 16'h0000;
        @(negedge clock) chk("clear", ex, evR);
      end
      cmd(3'h3, lf[15:0]);
      eseM = lf[15:0] & EVENT_USED;
      @(negedge clock) chk("ese", eseM, enR);
      cmd(3'h4, lf[15:0]);
      sreM = lf[7:0] & SRE_WRITABLE;
      @(negedge clock) chk("sre", {8'h00, sreM}, {8'h00, sreR});
    end
    @(posedge clock) sum <= 11'h000;
    cmd(3'h2, 16'h0000);
    cmd(3'h3, 16'h0010);
    cmd(3'h4, 16'h0060);
    pulse(6'h01, 1'b0);
    repeat (4) @(posedge clock);
    @(negedge clock) chk("srq set", 16'h0160, {7'h00, srq, stb});
    chk("poll rqs", 16'h0060, {8'h00, spl});
    cmd(3'h5, 16'h0000);
    @(posedge clock);
    @(negedge clock) chk("poll clear", 16'h0020, {7'h00, srq, spl});
    pulse(6'h00, 1'b1);
    repeat (2) @(posedge clock);
    @(negedge clock) chk("opc", 16'h0011, evR);
    // second reset in mid-run must bring back the power event and quiet outputs
    @(posedge clock) reset <= 1'b1;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    @(negedge clock) chk("reset event", 16'h0080, evR);
    chk("reset masks", 16'h0000, enR | {8'h00, sreR});
    chk("reset status", 16'h0000, {7'h00, srq, stb});
    test_done();
  end
  initial begin
    repeat (5000) @(posedge clock);
    errors++;
    test_done();
  end
endmodule // testbench
